// ==== byte_fifo.sv ====
`timescale 1ns/1ns
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // both sides
    fifo_if.store port
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    wire push = port.in_valid && port.in_ready;
    wire pop = port.out_valid && port.out_ready;

    assign port.in_ready = count != (AW+1)'(DEPTH);
    assign port.out_valid = count != '0;
    assign port.out_data = mem[rd_ptr];

    always_ff @(posedge clock) begin
        if (push) begin
            mem[wr_ptr] <= port.in_data;
        end
    end

    // pointers wrap naturally: depth is a power of two
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            wr_ptr <= wr_ptr + AW'(push);
            rd_ptr <= rd_ptr + AW'(pop);
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    fifo_bound_a: assert property (@(posedge clock) disable iff (rst)
        count <= (AW+1)'(DEPTH)) else $error("fifo count past depth");
endmodule

// ==== disk_iface.sv ====
// The implementer's own choices: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ns
`include "fdc_map.svh"
module disk_iface #(
    parameter int DRIVES = 4,
    parameter int FIFO_DEPTH = 16,
    parameter logic [7:0] BOOT_IMAGE [`BOOT_BYTES] = '{default: 8'h00}
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // register bus
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // host memory side, boot window
    input wire logic mem_read,
    input wire logic [15:0] mem_address,
    output logic boot_hit,
    output logic [7:0] boot_data,
    // board switches
    input wire logic [4:0] sw_base,
    input wire logic sw_boot,
    input wire logic sw_protect,
    // drive status
    input wire logic ready_n,
    input wire logic index_n,
    input wire logic track0_n,
    input wire logic media_protect_n,
    input wire logic read_data_n,
    // drive control
    output logic [DRIVES-1:0] select_n,
    output logic head_load_n,
    output logic dir_in_n,
    output logic step_n,
    output logic restore_n,
    output logic write_gate_n,
    output logic write_data_n
);
    localparam int BIT_CYC = `BIT_CYCLES;
    localparam int PULSE_CYC = (`PULSE_CYCLES < 1) ? 1 : `PULSE_CYCLES;
    localparam int BW = $clog2(BIT_CYC);
    localparam int PW = $clog2(PULSE_CYC + 1);

    // ----------------------------------------
    // input synchronisers
    // ----------------------------------------
    logic [11:0] pins_meta;
    logic [11:0] pins_s;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pins_meta <= 12'hF80;
            pins_s <= 12'hF80;
        end else begin
            pins_meta <= {read_data_n, media_protect_n, track0_n, index_n, ready_n,
                          sw_protect, sw_boot, sw_base};
            pins_s <= pins_meta;
        end
    end
    wire [4:0] base_s = pins_s[4:0];
    wire boot_sw_s = pins_s[5];
    wire protect_s = pins_s[6];
    // status lines are true when low
    wire drive_ready = !pins_s[7];
    wire index_seen = !pins_s[8];
    wire at_track0 = !pins_s[9];
    wire media_protect = !pins_s[10];
    wire read_bit = !pins_s[11];

    // ----------------------------------------
    // bus decode
    // ----------------------------------------
    function automatic logic [7:0] sel_decode(input logic [2:0] code);
        sel_decode = 8'h01 << code;
    endfunction

    logic ack;
    logic [7:0] ctrl;
    logic rx_full;
    fdc_pkg::byte_t rx_byte;
    fifo_if #(.WIDTH(8)) tx_q();

    wire port_match = avs_address[7:3] == base_s;
    wire [2:0] reg_index = avs_address[2:0];
    wire [7:0] hit = port_match ? sel_decode(reg_index) : 8'h00;
    wire data_stall = avs_write && hit[`REG_DATA] && !tx_q.in_ready;
    assign avs_waitrequest = (avs_read && !ack) || data_stall;
    wire wr_done = avs_write && !avs_waitrequest;
    wire rd_done = avs_read && !avs_waitrequest;
    wire ctrl_wr = wr_done && hit[`REG_CTRL];
    wire motion_wr = wr_done && hit[`REG_MOTION];
    wire boot_wr = wr_done && hit[`REG_BOOT];
    wire data_rd = rd_done && hit[`REG_DATA];

    // one byte moves per accepted bus access
    assign tx_q.in_valid = avs_write && hit[`REG_DATA];
    assign tx_q.in_data = avs_writedata[7:0];

    logic boot_active;
    logic ser_busy;
    wire [7:0] status = {ser_busy, boot_active, rx_full, media_protect,
                         at_track0, index_seen, drive_ready, protect_s};
    wire [7:0] read_mux = hit[`REG_CTRL] ? ctrl :
                          hit[`REG_STATUS] ? status :
                          hit[`REG_DATA] ? rx_byte : 8'h00;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ack <= 1'b0;
            avs_readdata <= 32'h00000000;
        end else begin
            ack <= avs_read && !ack;
            if (avs_read && !ack) begin
                avs_readdata <= {24'h000000, read_mux};
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ctrl <= `CTRL_RESET;
        end else if (ctrl_wr) begin
            ctrl <= avs_writedata[7:0];
        end
    end

    // ----------------------------------------
    // boot window
    // ----------------------------------------
    // switch is sampled only once the synchroniser has filled after reset
    logic [1:0] boot_wait;
    logic boot_armed;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            boot_wait <= 2'h0;
            boot_armed <= 1'b1;
            boot_active <= 1'b0;
        end else begin
            boot_wait <= boot_wait + 2'(boot_armed);
            if (boot_armed && boot_wait == 2'h3) begin
                boot_armed <= 1'b0;
                boot_active <= boot_sw_s;
            end else if (boot_wr || (boot_active && !boot_sw_s)) begin
                boot_active <= 1'b0;
            end
        end
    end

    wire in_rom = mem_address < 16'(`BOOT_BYTES);
    assign boot_hit = boot_active && mem_read && in_rom;
    // loader image: fetch the 128-byte first sector of track zero, then jump
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            boot_data <= 8'h00;
        end else begin
            boot_data <= BOOT_IMAGE[mem_address[4:0]];
        end
    end

    // ----------------------------------------
    // drive control lines
    // ----------------------------------------
    wire [7:0] sel_all = sel_decode(ctrl[`CTRL_SEL_HI:`CTRL_SEL_LO]);
    logic [PW-1:0] step_cnt;
    logic [PW-1:0] restore_cnt;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            select_n <= '1;
            head_load_n <= 1'b1;
            dir_in_n <= 1'b1;
            step_cnt <= '0;
            restore_cnt <= '0;
        end else begin
            select_n <= ~sel_all[DRIVES-1:0];
            head_load_n <= !ctrl[`CTRL_HEAD];
            dir_in_n <= !ctrl[`CTRL_DIR_IN];
            if (motion_wr && avs_writedata[`MOTION_STEP]) begin
                step_cnt <= PW'(PULSE_CYC);
            end else if (step_cnt != '0) begin
                step_cnt <= step_cnt - PW'(1);
            end
            if (motion_wr && avs_writedata[`MOTION_RESTORE]) begin
                restore_cnt <= PW'(PULSE_CYC);
            end else if (restore_cnt != '0) begin
                restore_cnt <= restore_cnt - PW'(1);
            end
        end
    end
    assign step_n = step_cnt == '0;
    assign restore_n = restore_cnt == '0;

    // ----------------------------------------
    // write serialiser
    // ----------------------------------------
    byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) tx_fifo (
        .clock(clock),
        .rst(rst),
        .port(tx_q)
    );

    fdc_pkg::ser_state_e ser_state;
    fdc_pkg::ser_state_e next_ser_state;
    logic [BW-1:0] tx_cnt;
    logic [3:0] tx_left;
    logic [7:0] tx_shift;
    wire write_ok = ctrl[`CTRL_WRITE] && !protect_s && !media_protect;
    wire tx_tick = ser_state == fdc_pkg::ser_shift && tx_cnt == BW'(BIT_CYC - 1);
    wire tx_load = ser_state == fdc_pkg::ser_idle && write_ok && tx_q.out_valid;
    assign tx_q.out_ready = tx_load;
    assign ser_busy = ser_state != fdc_pkg::ser_idle;

    always_comb begin
        next_ser_state = ser_state;
        unique case (ser_state)
            fdc_pkg::ser_idle: begin
                if (tx_load) begin
                    next_ser_state = fdc_pkg::ser_shift;
                end
            end
            fdc_pkg::ser_shift: begin
                if (!write_ok) begin
                    next_ser_state = fdc_pkg::ser_idle;
                end else if (tx_tick && tx_left == 4'h1) begin
                    next_ser_state = fdc_pkg::ser_done;
                end
            end
            fdc_pkg::ser_done: begin
                next_ser_state = fdc_pkg::ser_idle;
            end
            default: begin
                next_ser_state = fdc_pkg::ser_idle;
            end
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ser_state <= fdc_pkg::ser_idle;
            tx_cnt <= '0;
            tx_left <= 4'h0;
            tx_shift <= 8'h00;
        end else begin
            ser_state <= next_ser_state;
            tx_cnt <= (tx_load || tx_tick) ? '0 : tx_cnt + BW'(1);
            if (tx_load) begin
                tx_shift <= tx_q.out_data;
                tx_left <= 4'h8;
            end else if (tx_tick) begin
                tx_shift <= {tx_shift[6:0], 1'b0};
                tx_left <= tx_left - 4'h1;
            end
        end
    end

    // gate drops in the same cycle that protection appears
    assign write_gate_n = !(ser_state == fdc_pkg::ser_shift && write_ok);
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            write_data_n <= 1'b1;
        end else begin
            write_data_n <= !tx_shift[7];
        end
    end

    // ----------------------------------------
    // read deserialiser
    // ----------------------------------------
    // no clock recovery: bits are sampled on a free bit timer while reading
    logic [BW-1:0] rx_cnt;
    logic [2:0] rx_bits;
    logic [7:0] rx_shift;
    wire rx_tick = ctrl[`CTRL_READ] && rx_cnt == BW'(BIT_CYC - 1);
    wire rx_done = rx_tick && rx_bits == 3'h7;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rx_cnt <= '0;
            rx_bits <= 3'h0;
            rx_shift <= 8'h00;
            rx_byte <= 8'h00;
            rx_full <= 1'b0;
        end else begin
            rx_cnt <= (!ctrl[`CTRL_READ] || rx_tick) ? '0 : rx_cnt + BW'(1);
            rx_bits <= !ctrl[`CTRL_READ] ? 3'h0 : rx_bits + 3'(rx_tick);
            if (rx_tick) begin
                rx_shift <= {rx_shift[6:0], read_bit};
            end
            if (rx_done) begin
                rx_byte <= {rx_shift[6:0], read_bit};
            end
            // a byte landing on the read that empties the buffer wins
            rx_full <= rx_done || (rx_full && !data_rd);
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    switch_protect_a: assert property (
        protect_s |-> write_gate_n) else $error("write gate open under switch protect");
    media_protect_a: assert property (
        media_protect |-> write_gate_n) else $error("write gate open on protected media");
    boot_exit_a: assert property (
        boot_wr |=> !boot_active [*4]) else $error("boot ROM still mapped");
    boot_gate_a: assert property (
        boot_hit |-> boot_active && boot_sw_s) else $error("boot ROM answered while off");
    bit_period_a: assert property (
        (tx_tick && tx_left > 4'h1 && write_ok) |-> ##[400:400] (tx_tick || !write_ok))
        else $error("bit period not 400 cycles");
    select_one_a: assert property (
        $onehot0(~select_n)) else $error("more than one drive selected");
    step_width_a: assert property (
        $fell(step_n) |-> !step_n [*8]) else $error("step pulse too short");
    restore_width_a: assert property (
        $fell(restore_n) |-> !restore_n [*8]) else $error("restore pulse too short");
    head_load_a: assert property (
        ctrl_wr && !avs_writedata[`CTRL_HEAD] |=> ##1 head_load_n)
        else $error("head stays loaded");
    port_match_a: assert property (
        wr_done && !port_match |=> $stable(ctrl)) else $error("foreign port changed control");
    read_answer_a: assert property (
        avs_read && !ack |=> !avs_waitrequest || !avs_read) else $error("read not answered");
    byte_ready_a: assert property (
        rx_done |=> rx_full && rx_byte == {$past(rx_shift[6:0]), $past(read_bit)})
        else $error("read byte lost");

    boot_leave_c: cover property (boot_active ##1 !boot_active);
    byte_sent_c: cover property (ser_state == fdc_pkg::ser_done);
    byte_read_c: cover property (data_rd && rx_full);
    fifo_stall_c: cover property (data_stall);
endmodule

// ==== fdc_map.svh ====
`ifndef FDC_MAP_SVH
`define FDC_MAP_SVH

// ----------------------------------------
// register index (low three port address bits)
// ----------------------------------------
`define REG_CTRL 3'h0
`define REG_STATUS 3'h1
`define REG_DATA 3'h2
`define REG_MOTION 3'h3
`define REG_BOOT 3'h4

// ----------------------------------------
// field positions
// ----------------------------------------
`define CTRL_HEAD 0
`define CTRL_DIR_IN 1
`define CTRL_WRITE 2
`define CTRL_READ 3
`define CTRL_SEL_LO 4
`define CTRL_SEL_HI 6
`define MOTION_STEP 0
`define MOTION_RESTORE 1
`define CTRL_RESET 8'h00

// ----------------------------------------
// timing
// ----------------------------------------
`define CLOCK_HZ 100000000
`define BIT_RATE 250000
`define BIT_CYCLES (`CLOCK_HZ / `BIT_RATE)
`define PULSE_NS 1000
`define PULSE_CYCLES ((`PULSE_NS * (`CLOCK_HZ / 1000000) + 999) / 1000)
`define BOOT_BYTES 32
`define SECTOR_BYTES 128

`endif

// ==== fdc_pkg.sv ====
package fdc_pkg;
    typedef logic [7:0] byte_t;
    typedef enum logic [1:0] {
        ser_idle = 2'b00,
        ser_shift = 2'b01,
        ser_done = 2'b10
    } ser_state_e;
endpackage

// ==== fdd_model.sv ====
`timescale 1ns/1ns
module fdd_model (
    // clock
    input wire logic clock,
    // control from the interface, media protect from the test
    input wire logic [3:0] select_n,
    input wire logic head_load_n,
    input wire logic dir_in_n,
    input wire logic step_n,
    input wire logic restore_n,
    input wire logic write_gate_n,
    input wire logic write_data_n,
    input wire logic wp_media,
    // status to the interface
    output logic ready_n,
    output logic index_n,
    output logic track0_n,
    output logic media_protect_n,
    output logic read_data_n
);
    int track = 5;
    int rev = 0;
    int run = 0;
    logic [7:0] wr_q[$];
    int len_q[$];
    // ----------------------------------------
    // status lines, low is true
    // ----------------------------------------
    assign ready_n = 1'b0;
    assign index_n = rev >= 20;
    assign track0_n = track != 0;
    assign media_protect_n = !wp_media;
    // steady one bits only while drive 0 has its head loaded
    assign read_data_n = !(head_load_n === 1'b0 && select_n[0] === 1'b0);
    always @(posedge clock) begin
        rev <= (rev == 9999) ? 0 : rev + 1;
        run <= (write_gate_n === 1'b0) ? run + 1 : 0;
        if (write_gate_n !== 1'b0 && run != 0) begin
            len_q.push_back(run);
        end
    end
    always @(negedge restore_n) track = 0;
    always @(negedge step_n) track = (dir_in_n === 1'b0) ? track + 1 : (track > 0 ? track - 1 : 0);
    // ----------------------------------------
    // write capture, mid-bit sampling
    // ----------------------------------------
    initial begin : capture
        logic [7:0] b;
        forever begin
            @(negedge write_gate_n);
            b = 8'h00;
            repeat (200) @(posedge clock);
            for (int i = 0; i < 8; i++) begin
                b = {b[6:0], ~write_data_n};
                if (i < 7) begin
                    repeat (400) @(posedge clock);
                end
            end
            wr_q.push_back(b);
        end
    end
endmodule

// ==== fifo_if.sv ====
`timescale 1ns/1ns
interface fifo_if #(parameter int WIDTH = 8);
    logic [WIDTH-1:0] in_data;
    logic in_valid;
    logic in_ready;
    logic [WIDTH-1:0] out_data;
    logic out_valid;
    logic out_ready;
    modport store (
        input in_data, in_valid, out_ready,
        output in_ready, out_data, out_valid
    );
    modport user (
        output in_data, in_valid, out_ready,
        input in_ready, out_data, out_valid
    );
endinterface

// ==== floppy_disk_host_interface_test.sv ====
`timescale 1ns/1ns
module floppy_disk_host_interface_test;
    localparam logic [7:0] ROM [32] = '{0: 8'hC3, 5: 8'h5A, 31: 8'hA5, default: 8'h00};
    localparam logic [4:0] BASE = 5'h0A;
    logic clock, rst, avs_read, avs_write, avs_waitrequest, mem_read, boot_hit;
    logic [7:0] avs_address, boot_data;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic [15:0] mem_address;
    logic [4:0] sw_base;
    logic sw_boot, sw_protect, wp_media;
    logic ready_n, index_n, track0_n, media_protect_n, read_data_n;
    logic [3:0] select_n;
    logic head_load_n, dir_in_n, step_n, restore_n, write_gate_n, write_data_n;
    logic [7:0] sent[$];
    int miscompares = 0;
    int samples_checked = 0;
    int n;
    disk_iface #(.DRIVES(4), .FIFO_DEPTH(16), .BOOT_IMAGE(ROM)) uut (.clock, .rst,
        .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
        .avs_waitrequest, .mem_read, .mem_address, .boot_hit, .boot_data, .sw_base,
        .sw_boot, .sw_protect, .ready_n, .index_n, .track0_n, .media_protect_n,
        .read_data_n, .select_n, .head_load_n, .dir_in_n, .step_n, .restore_n,
        .write_gate_n, .write_data_n);
    fdd_model model (.clock, .select_n, .head_load_n, .dir_in_n, .step_n, .restore_n,
        .write_gate_n, .write_data_n, .wp_media, .ready_n, .index_n, .track0_n,
        .media_protect_n, .read_data_n);
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // ----------------------------------------
    // checking and closing
    // ----------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        samples_checked++;
        if (seen !== want) begin
            miscompares++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, want);
        end
    endtask
    task automatic print_verdict();
        if (miscompares == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic timed_out(input logic hung);
        if (hung) begin
            miscompares++;
            $display("[ERR] %0t wait ran out", $time);
            print_verdict();
        end
    endtask
    // ----------------------------------------
    // bus master, request held until waitrequest low
    // ----------------------------------------
    task automatic wait_accept();
        int k;
        k = 0;
        do begin
            @(posedge clock);
            k++;
        end while (avs_waitrequest !== 1'b0 && k < 20000);
        timed_out(avs_waitrequest !== 1'b0);
    endtask
    task automatic bus_write(input logic [2:0] idx, input logic [7:0] d,
                             input logic [4:0] b = BASE);
        @(posedge clock);
        avs_address <= {b, idx};
        avs_writedata <= {24'h000000, d};
        avs_write <= 1'b1;
        wait_accept();
        avs_write <= 1'b0;
    endtask
    task automatic bus_read(input logic [2:0] idx, input logic [4:0] b = BASE);
        @(posedge clock);
        avs_address <= {b, idx};
        avs_read <= 1'b1;
        wait_accept();
        rd = avs_readdata;
        avs_read <= 1'b0;
    endtask
    task automatic do_reset(input logic boot);
        sw_boot <= boot;
        rst <= 1'b1;
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        repeat (8) @(posedge clock);
    endtask
    // memory strobe held two cycles, no wait states
    task automatic boot_probe(input logic [15:0] a, input logic hit, input logic [7:0] d);
        @(posedge clock);
        mem_read <= 1'b1;
        mem_address <= a;
        @(posedge clock);
        #1;
        check(boot_hit, hit);
        if (hit) begin
            check(boot_data, d);
        end
        @(posedge clock);
        mem_read <= 1'b0;
    endtask
    task automatic motion(input logic [7:0] cmd);
        bus_write(3'h3, cmd);
        n = 0;
        repeat (150) begin
            @(posedge clock);
            if ((cmd[0] ? step_n : restore_n) === 1'b0) n++;
        end
    endtask
    task automatic wait_rx();
        int k;
        k = 0;
        do begin
            bus_read(3'h1);
            k++;
        end while (rd[5] !== 1'b1 && k < 2000);
        timed_out(rd[5] !== 1'b1);
    endtask
    task automatic wait_sent(input int cnt);
        n = 0;
        while (model.len_q.size() < cnt && n < 60000) begin
            @(posedge clock);
            n++;
        end
        timed_out(model.len_q.size() < cnt);
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        {avs_read, avs_write, mem_read, sw_protect, wp_media} = 5'h00;
        avs_address = 8'h00;
        avs_writedata = 32'h00000000;
        mem_address = 16'h0000;
        sw_base = BASE;
        sw_boot = 1'b1;
        rst = 1'b1;
        do_reset(1'b1);
        boot_probe(16'h0005, 1'b1, 8'h5A);
        boot_probe(16'h001F, 1'b1, 8'hA5);
        boot_probe(16'h0020, 1'b0, 8'h00);
        bus_read(3'h1);
        check(rd[6], 1'b1);
        bus_write(3'h4, 8'h00);
        boot_probe(16'h0005, 1'b0, 8'h00);
        do_reset(1'b0);
        boot_probe(16'h0005, 1'b0, 8'h00);
        bus_write(3'h0, 8'h0F, BASE ^ 5'h01);
        bus_read(3'h0, BASE ^ 5'h01);
        check(rd, 32'h00000000);
        bus_read(3'h0);
        check(rd, 32'h00000000);
        for (int c = 0; c < 8; c++) begin
            bus_write(3'h0, {1'b0, c[2:0], 4'h3});
            repeat (2) @(posedge clock);
            check(select_n, c < 4 ? 4'(~(4'h1 << c)) : 4'hF);
            check({head_load_n, dir_in_n}, 2'b00);
            bus_read(3'h0);
            check(rd, {24'h000000, 1'b0, c[2:0], 4'h3});
        end
        // select code zero selects drive 0 again
        bus_write(3'h0, 8'h00);
        repeat (2) @(posedge clock);
        check({select_n[0], head_load_n, dir_in_n}, 3'b011);
        bus_read(3'h1);
        check({rd[3], rd[1]}, 2'b01);
        motion(8'h02);
        check(n, 100);
        bus_read(3'h1);
        check(rd[3], 1'b1);
        bus_write(3'h0, 8'h02);
        motion(8'h01);
        check(n, 100);
        bus_read(3'h1);
        check(rd[3], 1'b0);
        bus_write(3'h0, 8'h00);
        motion(8'h01);
        bus_read(3'h1);
        check(rd[3], 1'b1);
        bus_write(3'h0, 8'h09);
        wait_rx();
        bus_read(3'h2);
        wait_rx();
        bus_read(3'h2);
        check(rd, 32'h000000FF);
        sw_protect <= 1'b1;
        bus_write(3'h0, 8'h04);
        for (int i = 0; i < 16; i++) begin
            bus_write(3'h2, 8'h30 + 8'(i));
            sent.push_back(8'h30 + 8'(i));
        end
        bus_read(3'h1);
        check(rd[0], 1'b1);
        repeat (500) @(posedge clock);
        check(model.len_q.size(), 0);
        sent.push_back(8'hC5);
        fork
            bus_write(3'h2, 8'hC5);
            begin
                repeat (50) @(posedge clock);
                check(avs_waitrequest, 1'b1);
                sw_protect <= 1'b0;
            end
        join
        wait_sent(17);
        for (int i = 0; i < 17; i++) begin
            check(model.wr_q[i], sent[i]);
            check(model.len_q[i], 3200);
        end
        wp_media <= 1'b1;
        repeat (4) @(posedge clock);
        bus_write(3'h2, 8'h5C);
        repeat (1000) @(posedge clock);
        check(write_gate_n, 1'b1);
        check(model.len_q.size(), 17);
        bus_read(3'h1);
        check(rd[4], 1'b1);
        wp_media <= 1'b0;
        wait_sent(18);
        check(model.wr_q[17], 8'h5C);
        print_verdict();
    end
endmodule
